// ### hdl/dcs_top.sv
// Purpose: Distributed clock unit: ns system time, two compare channels,
//          two capture channels, delay-measurement latches, AHB-Lite slave.
// Assumes: Frame strobes come from same-clock logic; pins are asynchronous.
// Notes:   Every bus transfer takes one wait state.
// Function
// - Keep a 64-bit local system time counted in nanoseconds.
// - Reduced mode holds 32 bits and wraps to zero, counting on.
// - Time zero stands for midnight, first of January 2000.
// - Counter steps 10 ns; the ones digit is left for fine adjustment.
// - Master loads world time at startup; node then free runs.
// - Synchronised nodes agree with the reference within 100 ns.
// - Two compare channels each give a sync pulse and interrupt.
// - Single-shot channel fires once, then idles until reprogrammed.
// - Cyclic channel reloads its next target after each firing.
// - Sync action selectable: write outputs, read inputs, start controller.
// - Capture copies the local time into its buffer at once.
// - Capture sources: frame start, frame end, pin edge, controller access.
// - Input sampling reads pin levels at the sync event and holds them.
// - Process-data frame gets the sampled bits inserted on the fly.
// - Sampling must precede the frame; otherwise stale data stay.
// - Sync pulses repeat at the master's constant cycle after the shift.
// - Delay-measurement frame latches receive time per direction.
`timescale 1ns/1ps
module dcs_top (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	input  wire dcs_pkg::dcs_frame_s    frame_in,
	output logic      [7:0]             frame_out_data,
	output logic                        frame_out_vld,
	input  wire logic [1:0]             dm_rx,
	input  wire logic                   uc_comm,
	input  wire logic [7:0]             in_pins,
	input  wire logic [1:0]             latch_pin,
	output logic                        compare_pulse_a,
	output logic                        compare_pulse_b,
	output dcs_pkg::dcs_act_s           act,
	output logic                        irq
);
	dcs_pkg::dcs_bus_e   state_reg;
	dcs_pkg::dcs_ctrl_s  ctrl_reg;
	dcs_pkg::dcs_act_s   act_reg;
	logic [7:0]          addr_reg;
	logic                wr_reg;
	logic                hready_reg;
	logic [31:0]         hrdata_reg;
	logic [31:0]         rdata_c;
	logic                wsel;
	logic                rsel;
	logic [63:0]         time_reg;
	logic [63:0]         time_next;
	logic [63:0]         tcmp;
	logic [31:0]         time_hi_sh;
	logic [31:0]         time_hi_snap;
	logic [3:0]          adj_reg;
	logic [7:0]          pin_s1;
	logic [7:0]          pin_s2;
	logic [1:0]          lat_s1;
	logic [1:0]          lat_s2;
	logic [1:0]          lat_s3;
	logic [7:0]          sample_reg;
	logic                fresh_reg;
	logic [7:0]          ins_pos_reg;
	logic [7:0]          pos_reg;
	logic [7:0]          cur_pos;
	logic [7:0]          fout_reg;
	logic                fvld_reg;
	logic [1:0]          fire;
	logic [1:0]          cap_evt;
	logic [1:0]          pulse_reg;
	logic                rd_evt;
	logic                stale_evt;
	logic [5:0]          st_reg;
	logic [5:0]          mask_reg;
	logic [5:0]          ev;
	logic                irq_reg;
	logic [63:0]         tgt_w [2];
	logic [31:0]         cyc_w [2];
	logic [63:0]         cap_w [2];
	logic [31:0]         dm_w  [2];

	function automatic logic wr_hit(input logic [7:0] off);
		wr_hit = wsel && (addr_reg == off);
	endfunction

	// Bus slave: one wait state lets read data leave a flip-flop.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg  <= dcs_pkg::BUS_IDLE;
			addr_reg   <= 8'h00;
			wr_reg     <= 1'b0;
			hready_reg <= 1'b1;
			hrdata_reg <= 32'h0000_0000;
		end
		else
		begin
			unique case (state_reg)
				dcs_pkg::BUS_IDLE:
				begin
					if (hsel && htrans[1] && hready)
					begin
						// Misaligned, non-word or out-of-range maps nowhere.
						addr_reg   <= ((|haddr[31:8]) || (|haddr[1:0]) ||
							(hsize != dcs_pkg::HSIZE_WORD)) ?
							dcs_pkg::A_NONE : haddr[7:0];
						wr_reg     <= hwrite;
						hready_reg <= 1'b0;
						state_reg  <= dcs_pkg::BUS_DATA;
					end
				end
				dcs_pkg::BUS_DATA:
				begin
					hrdata_reg <= wr_reg ? 32'h0000_0000 : rdata_c;
					hready_reg <= 1'b1;
					state_reg  <= dcs_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	assign wsel = (state_reg == dcs_pkg::BUS_DATA) && wr_reg;
	assign rsel = (state_reg == dcs_pkg::BUS_DATA) && !wr_reg;

	always_comb
	begin
		rdata_c = 32'h0000_0000;
		unique case (addr_reg)
			dcs_pkg::A_CTRL:        rdata_c = ctrl_reg;
			dcs_pkg::A_TIME_LO:     rdata_c = time_reg[31:0];
			dcs_pkg::A_TIME_HI:     rdata_c = time_hi_snap;
			dcs_pkg::A_ADJUST:      rdata_c = {28'h0, adj_reg};
			dcs_pkg::A_START_A_LO:  rdata_c = tgt_w[0][31:0];
			dcs_pkg::A_START_A_HI:  rdata_c = tgt_w[0][63:32];
			8'h18:                  rdata_c = tgt_w[1][31:0];
			8'h1c:                  rdata_c = tgt_w[1][63:32];
			dcs_pkg::A_CYCLE_A:     rdata_c = cyc_w[0];
			8'h24:                  rdata_c = cyc_w[1];
			dcs_pkg::A_CAP0_LO:     rdata_c = cap_w[0][31:0];
			dcs_pkg::A_CAP0_HI:     rdata_c = cap_w[0][63:32];
			8'h30:                  rdata_c = cap_w[1][31:0];
			8'h34:                  rdata_c = cap_w[1][63:32];
			dcs_pkg::A_DM0:         rdata_c = dm_w[0];
			8'h3c:                  rdata_c = dm_w[1];
			dcs_pkg::A_SAMPLE:      rdata_c = {24'h0, sample_reg};
			dcs_pkg::A_IRQ_STATUS:  rdata_c = {26'h0, st_reg};
			dcs_pkg::A_IRQ_MASK:    rdata_c = {26'h0, mask_reg};
			dcs_pkg::A_INS_POS:     rdata_c = {24'h0, ins_pos_reg};
			default:                rdata_c = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg    <= dcs_pkg::CTRL_RST;
			adj_reg     <= 4'h0;
			time_hi_sh  <= 32'h0000_0000;
			mask_reg    <= 6'h00;
			ins_pos_reg <= 8'h00;
		end
		else
		begin
			if (wr_hit(dcs_pkg::A_CTRL))
				ctrl_reg <= hwdata & dcs_pkg::CTRL_MASK;
			if (wr_hit(dcs_pkg::A_ADJUST))
				adj_reg <= hwdata[3:0];
			if (wr_hit(dcs_pkg::A_TIME_HI))
				time_hi_sh <= hwdata;
			if (wr_hit(dcs_pkg::A_IRQ_MASK))
				mask_reg <= hwdata[5:0];
			if (wr_hit(dcs_pkg::A_INS_POS))
				ins_pos_reg <= hwdata[7:0];
		end
	end

	// Reading the low word freezes the high word, so a 64-bit read is whole.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			time_hi_snap <= 32'h0000_0000;
		else if (rsel && (addr_reg == dcs_pkg::A_TIME_LO))
			time_hi_snap <= time_reg[63:32];
	end

	always_comb
	begin
		time_next = time_reg + dcs_pkg::STEP_PER_CLK +
			{{60{adj_reg[3]}}, adj_reg};
		if (wr_hit(dcs_pkg::A_TIME_LO))
			time_next = {time_hi_sh, hwdata};
		if (ctrl_reg.mode32)
			time_next[63:32] = 32'h0000_0000;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			time_reg <= 64'h0000_0000_0000_0000;
		else
			time_reg <= time_next;
	end

	assign tcmp = ctrl_reg.mode32 ? {32'h0, time_reg[31:0]} : time_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1 <= 8'h00;
			pin_s2 <= 8'h00;
			lat_s1 <= 2'h0;
			lat_s2 <= 2'h0;
			lat_s3 <= 2'h0;
		end
		else
		begin
			pin_s1 <= in_pins;
			pin_s2 <= pin_s1;
			lat_s1 <= latch_pin;
			lat_s2 <= lat_s1;
			lat_s3 <= lat_s2;
		end
	end

	for (genvar i = 0; i < dcs_pkg::NCH; i++)
	begin : g_ch
		localparam logic [7:0] OFF_LO =
			8'(dcs_pkg::A_START_A_LO + dcs_pkg::STRIDE_START * i);
		localparam logic [7:0] OFF_HI =
			8'(dcs_pkg::A_START_A_HI + dcs_pkg::STRIDE_START * i);
		localparam logic [7:0] OFF_CY =
			8'(dcs_pkg::A_CYCLE_A + dcs_pkg::STRIDE_CYCLE * i);
		logic [63:0] tgt_reg;
		logic [63:0] tgt_m;
		logic [31:0] cyc_reg;
		logic        armed_reg;
		logic [63:0] cap_reg;
		logic [31:0] dm_reg;

		assign tgt_m = ctrl_reg.mode32 ? {32'h0, tgt_reg[31:0]} : tgt_reg;
		assign fire[i] = armed_reg && ctrl_reg.cmp_en[i] && (tcmp >= tgt_m);

		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				tgt_reg   <= 64'h0000_0000_0000_0000;
				cyc_reg   <= 32'h0000_0000;
				armed_reg <= 1'b0;
			end
			else
			begin
				if (fire[i])
				begin
					if (ctrl_reg.cyc[i])
						tgt_reg <= tgt_reg + {32'h0, cyc_reg};
					else
						armed_reg <= 1'b0;
				end
				if (wr_hit(OFF_HI))
					tgt_reg[63:32] <= hwdata;
				// Writing the low word arms the channel.
				if (wr_hit(OFF_LO))
				begin
					tgt_reg[31:0] <= hwdata;
					armed_reg     <= 1'b1;
				end
				if (wr_hit(OFF_CY))
					cyc_reg <= hwdata;
			end
		end

		always_comb
		begin
			unique case (dcs_pkg::dcs_src_e'(ctrl_reg.cap_src[i]))
				dcs_pkg::SRC_SOF: cap_evt[i] = frame_in.sof;
				dcs_pkg::SRC_EOF: cap_evt[i] = frame_in.eof;
				dcs_pkg::SRC_PIN: cap_evt[i] = lat_s2[i] && !lat_s3[i];
				dcs_pkg::SRC_UC:  cap_evt[i] = uc_comm;
			endcase
		end

		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				cap_reg <= 64'h0000_0000_0000_0000;
				dm_reg  <= 32'h0000_0000;
			end
			else
			begin
				if (cap_evt[i])
					cap_reg <= time_reg;
				if (dm_rx[i])
					dm_reg <= time_reg[31:0];
			end
		end

		assign tgt_w[i] = tgt_reg;
		assign cyc_w[i] = cyc_reg;
		assign cap_w[i] = cap_reg;
		assign dm_w[i]  = dm_reg;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			act_reg   <= 3'h0;
			pulse_reg <= 2'h0;
		end
		else
		begin
			pulse_reg       <= fire;
			act_reg.wr_out  <=
				(fire[0] && ctrl_reg.act[0] == dcs_pkg::ACT_WR_OUT) ||
				(fire[1] && ctrl_reg.act[1] == dcs_pkg::ACT_WR_OUT);
			act_reg.rd_in   <= rd_evt;
			act_reg.uc_start <=
				(fire[0] && ctrl_reg.act[0] == dcs_pkg::ACT_UC) ||
				(fire[1] && ctrl_reg.act[1] == dcs_pkg::ACT_UC);
		end
	end

	assign rd_evt = (fire[0] && ctrl_reg.act[0] == dcs_pkg::ACT_RD_IN) ||
		(fire[1] && ctrl_reg.act[1] == dcs_pkg::ACT_RD_IN);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sample_reg <= 8'h00;
			fresh_reg  <= 1'b0;
		end
		else
		begin
			if (rd_evt)
				sample_reg <= pin_s2;
			// A sample in the frame's first cycle counts for the next one.
			if (rd_evt)
				fresh_reg <= 1'b1;
			else if (frame_in.sof && frame_in.pd)
				fresh_reg <= 1'b0;
		end
	end

	assign stale_evt = frame_in.sof && frame_in.pd && !fresh_reg;
	assign cur_pos   = frame_in.sof ? 8'h00 : pos_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pos_reg  <= 8'h00;
			fout_reg <= 8'h00;
			fvld_reg <= 1'b0;
		end
		else
		begin
			fvld_reg <= frame_in.vld;
			if (frame_in.vld)
				pos_reg <= cur_pos + 8'h01;
			if (frame_in.vld && frame_in.pd && cur_pos == ins_pos_reg)
				fout_reg <= sample_reg;
			else
				fout_reg <= frame_in.data;
		end
	end

	assign ev = {|dm_rx, stale_evt, cap_evt, fire};

	// Hardware set wins over a write-one clear in the same cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg  <= 6'h00;
			irq_reg <= 1'b0;
		end
		else
		begin
			if (wr_hit(dcs_pkg::A_IRQ_STATUS))
				st_reg <= (st_reg & ~hwdata[5:0]) | ev;
			else
				st_reg <= st_reg | ev;
			irq_reg <= |(st_reg & mask_reg);
		end
	end

	assign hrdata          = hrdata_reg;
	assign hreadyout       = hready_reg;
	assign hresp           = 1'b0;
	assign frame_out_data  = fout_reg;
	assign frame_out_vld   = fvld_reg;
	assign compare_pulse_a = pulse_reg[0];
	assign compare_pulse_b = pulse_reg[1];
	assign act             = act_reg;
	assign irq             = irq_reg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_acc;
		state_reg == dcs_pkg::BUS_IDLE && hsel && htrans[1] && hready;
	endsequence
	sequence s_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_bus_wait;
		s_acc |=> s_ans;
	endproperty
	a_bus_wait: assert property (p_bus_wait)
		else $error("bus answer not after one wait state");
	property p_step;
		(adj_reg == 4'h0 && !wr_hit(dcs_pkg::A_TIME_LO)
			&& !ctrl_reg.mode32) |=>
			(time_reg - $past(time_reg)) == dcs_pkg::STEP_PER_CLK;
	endproperty
	a_step: assert property (p_step)
		else $error("time did not advance by 10 ns");
	property p_wrap;
		ctrl_reg.mode32 |=> time_reg[63:32] == 32'h0000_0000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("reduced counter has high bits set");
	property p_pulse;
		fire[0] |=> compare_pulse_a ##1 compare_pulse_a == $past(fire[0]);
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("sync pulse a not raised for one cycle");
	property p_single;
		fire[0] && !ctrl_reg.cyc[0] && !wr_hit(dcs_pkg::A_START_A_LO)
			|=> !g_ch[0].armed_reg;
	endproperty
	a_single: assert property (p_single)
		else $error("single shot channel stayed armed");
	property p_cyclic;
		fire[1] && ctrl_reg.cyc[1] && !wsel |=>
			tgt_w[1] == $past(tgt_w[1]) + {32'h0, cyc_w[1]};
	endproperty
	a_cyclic: assert property (p_cyclic)
		else $error("cyclic target not reloaded");
	property p_reach;
		g_ch[0].armed_reg && ctrl_reg.cmp_en[0] && tcmp >= g_ch[0].tgt_m
			|=> compare_pulse_a;
	endproperty
	a_reach: assert property (p_reach)
		else $error("compare a missed a passed target");
	property p_capture;
		cap_evt[0] |=> cap_w[0] == $past(time_reg);
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture 0 did not hold the event time");
	property p_sample;
		rd_evt |=> sample_reg == $past(pin_s2) && act.rd_in;
	endproperty
	a_sample: assert property (p_sample)
		else $error("inputs not sampled at sync event");
	property p_insert;
		frame_in.vld && frame_in.pd && cur_pos == ins_pos_reg
			|=> frame_out_vld && frame_out_data == $past(sample_reg);
	endproperty
	a_insert: assert property (p_insert)
		else $error("sampled byte not inserted in frame");
	property p_dm;
		dm_rx[1] |=> dm_w[1] == $past(time_reg[31:0]);
	endproperty
	a_dm: assert property (p_dm)
		else $error("delay measurement time not latched");
endmodule

// ### hdl/dcs_pkg.sv
// Purpose: Shared constants and types of the distributed clock sync/latch unit.
// Assumes: 32-bit AHB-Lite register bus, one clock at 100 MHz.
// Notes:   Byte offsets are word aligned; 0xff marks an unmapped access.
package dcs_pkg;
	// The counter's unit is 1 ns; one clock of 10 ns advances it by 10.
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          STEP_NS       = 10;
	localparam logic [63:0] STEP_PER_CLK  =
		64'(STEP_NS * (CLK_PERIOD_NS / STEP_NS));
	localparam int          NCH           = 2;
	localparam int          IN_W          = 8;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	localparam logic [7:0]  A_CTRL        = 8'h00;
	localparam logic [7:0]  A_TIME_LO     = 8'h04;
	localparam logic [7:0]  A_TIME_HI     = 8'h08;
	localparam logic [7:0]  A_ADJUST      = 8'h0c;
	localparam logic [7:0]  A_START_A_LO  = 8'h10;
	localparam logic [7:0]  A_START_A_HI  = 8'h14;
	localparam logic [7:0]  A_CYCLE_A     = 8'h20;
	localparam logic [7:0]  A_CAP0_LO     = 8'h28;
	localparam logic [7:0]  A_CAP0_HI     = 8'h2c;
	localparam logic [7:0]  A_DM0         = 8'h38;
	localparam logic [7:0]  A_SAMPLE      = 8'h40;
	localparam logic [7:0]  A_IRQ_STATUS  = 8'h44;
	localparam logic [7:0]  A_IRQ_MASK    = 8'h48;
	localparam logic [7:0]  A_INS_POS     = 8'h4c;
	localparam logic [7:0]  A_NONE        = 8'hff;
	// Channel b sits at these strides above channel a.
	localparam int          STRIDE_START  = 8;
	localparam int          STRIDE_CYCLE  = 4;
	localparam int          STRIDE_CAP    = 8;
	localparam int          STRIDE_DM     = 4;

	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK     = 32'h0000_1fff;
	localparam int          IRQ_CMP       = 0;
	localparam int          IRQ_CAP       = 2;
	localparam int          IRQ_STALE     = 4;
	localparam int          IRQ_DM        = 5;
	localparam int          IRQ_W         = 6;

	typedef enum logic {BUS_IDLE = 1'b0, BUS_DATA = 1'b1} dcs_bus_e;
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00, ACT_WR_OUT = 2'b01,
		ACT_RD_IN = 2'b10, ACT_UC = 2'b11} dcs_act_e;
	typedef enum logic [1:0] {
		SRC_SOF = 2'b00, SRC_EOF = 2'b01,
		SRC_PIN = 2'b10, SRC_UC = 2'b11} dcs_src_e;

	typedef struct packed {
		logic [18:0]      rsvd;
		logic [1:0][1:0]  cap_src;
		logic [1:0][1:0]  act;
		logic [1:0]       cyc;
		logic [1:0]       cmp_en;
		logic             mode32;
	} dcs_ctrl_s;

	typedef struct packed {
		logic       sof;
		logic       eof;
		logic       vld;
		logic       pd;
		logic [7:0] data;
	} dcs_frame_s;

	typedef struct packed {
		logic wr_out;
		logic rd_in;
		logic uc_start;
	} dcs_act_s;
endpackage

// ### sim/dcs_frame_src.sv
// Purpose: Far-side model: frame strobes and delay-measurement pulses.
// Assumes: Same clock as the unit; bytes are numbered from the start strobe.
// Notes:   Idle data shows the inverse of the last byte, never a held value.
`timescale 1ns/1ps
module dcs_frame_src (
	input  wire logic          hclk,
	output dcs_pkg::dcs_frame_s frame,
	output logic [1:0]         dm_rx
);
	initial
	begin
		frame = '0;
		dm_rx = 2'b00;
	end

	task automatic send(input logic pd, input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge hclk);
			frame <= '{sof: (i == 0), eof: (i == n - 1), vld: 1'b1,
				pd: pd, data: 8'(8'h10 + i)};
		end
		@(posedge hclk);
		frame <= '{sof: 1'b0, eof: 1'b0, vld: 1'b0, pd: 1'b0,
			data: 8'(8'hf0 - n)};
	endtask

	task automatic dm(input int d);
		@(posedge hclk);
		dm_rx[d] <= 1'b1;
		@(posedge hclk);
		dm_rx <= 2'b00;
	endtask
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench of the distributed clock unit.
// Assumes: One wait state per bus transfer; hready looped from hreadyout.
// Notes:   Time stamps are judged against time reads taken around the event.
`timescale 1ns/1ps
module testbench;
	logic                hclk;
	logic                hresetn;
	logic [31:0]         haddr;
	logic [1:0]          htrans;
	logic                hwrite;
	logic [31:0]         hwdata;
	logic [31:0]         hrdata;
	logic                hreadyout;
	logic                hresp;
	dcs_pkg::dcs_frame_s frame;
	logic [7:0]          fo_data;
	logic                fo_vld;
	logic [1:0]          dm_rx;
	logic                uc_comm;
	logic [7:0]          in_pins;
	logic [1:0]          latch_pin;
	logic                pa;
	logic                pb;
	dcs_pkg::dcs_act_s   act;
	logic                irq;
	int                  failures;
	int                  n_tests;
	int                  cyc;
	int                  npa;
	int                  nact [3];
	int                  i;
	int                  j;
	int                  c0;
	logic [7:0]          fo [$];
	logic [31:0]         r;
	logic [31:0]         t0;
	logic [31:0]         t1;

	dcs_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(dcs_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.frame_in(frame), .frame_out_data(fo_data), .frame_out_vld(fo_vld),
		.dm_rx(dm_rx), .uc_comm(uc_comm), .in_pins(in_pins),
		.latch_pin(latch_pin), .compare_pulse_a(pa), .compare_pulse_b(pb),
		.act(act), .irq(irq));
	dcs_frame_src partner_u (.hclk(hclk), .frame(frame), .dm_rx(dm_rx));

	initial hclk = 1'b0;
	always #5 hclk = ~hclk;

	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		npa <= npa + 32'(pa === 1'b1);
		nact[0] <= nact[0] + 32'(act.wr_out === 1'b1);
		nact[1] <= nact[1] + 32'(act.rd_in === 1'b1);
		nact[2] <= nact[2] + 32'(act.uc_start === 1'b1);
		if (fo_vld === 1'b1)
			fo.push_back(fo_data);
	end

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict;
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic bus_wait;
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 40);
		if (k >= 40)
		begin
			failures++;
			print_verdict;
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		bus_wait;
		htrans <= 2'b00;
		hwdata <= d;
		bus_wait;
		r = hrdata;
		chk("hresp", 64'h0, 64'(hresp));
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic set_time(input logic [31:0] lo);
		wr(8'h08, 32'h0);
		wr(8'h04, lo);
	endtask

	task automatic arm(input int ch, input logic [31:0] tgt);
		wr(8'(8'h14 + 8 * ch), 32'h0);
		wr(8'(8'h10 + 8 * ch), tgt);
	endtask

	task automatic wait_pulse(input int ch);
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end while ((ch != 0 ? pb : pa) !== 1'b1 && k < 3000);
		if (k >= 3000)
		begin
			failures++;
			print_verdict;
		end
	endtask

	task automatic chk_lat(input logic [7:0] a, input int b);
		repeat (4) @(posedge hclk);
		rd(a);
		t1 = r;
		rd(8'h04);
		chk("stamp", 64'h1, 64'(t1 > t0 && t1 < r));
		rd(8'h44);
		chk("stamp_flag", 64'h1, 64'(r[b]));
	endtask

	task automatic t_reset;
		chk("irq_rst", 64'h0, 64'(irq));
		rd(8'h04);
		// Released at one edge, stepped at the next two, then read.
		chk("epoch", dcs_pkg::STEP_PER_CLK * 2, 64'(r));
		rd(8'h00);
		chk("ctrl_rst", 64'(dcs_pkg::CTRL_RST), 64'(r));
		wr(8'h80, 32'hffff_ffff);
		rd(8'h80);
		chk("unmapped", 64'h0, 64'(r));
	endtask

	task automatic t_time;
		// Plain step, then a trim of +3 and of -1 per clock.
		for (i = 0; i < 3; i++)
		begin
			j = (i == 2) ? -1 : 3 * i;
			wr(8'h0c, 32'(j));
			rd(8'h04);
			t0 = r;
			c0 = cyc;
			repeat (7) @(posedge hclk);
			rd(8'h04);
			j = (int'(dcs_pkg::STEP_PER_CLK) + j) * (cyc - c0);
			chk("step", 64'(j), 64'(r - t0));
		end
		wr(8'h0c, 32'h0);
		set_time(32'hffff_ff00);
		repeat (40) @(posedge hclk);
		rd(8'h04);
		rd(8'h08);
		chk("carry", 64'h1, 64'(r));
		wr(8'h00, 32'h1);
		set_time(32'hffff_ff00);
		repeat (40) @(posedge hclk);
		rd(8'h04);
		t0 = r;
		rd(8'h08);
		chk("wrap_hi", 64'h0, 64'(r));
		chk("wrap_lo", 64'h1, 64'(t0 < 32'h400));
		wr(8'h00, 32'h0);
	endtask

	task automatic t_once;
		wr(8'h48, 32'h1);
		set_time(32'h0);
		wr(8'h00, 32'h2);
		arm(0, 32'd1005);
		c0 = npa;
		wait_pulse(0);
		rd(8'h04);
		chk("fire_time", 64'h1, 64'(r >= 1005 && r < 1105));
		chk("irq", 64'h1, 64'(irq));
		rd(8'h44);
		chk("cmp_flag", 64'h1, 64'(r[0]));
		repeat (200) @(posedge hclk);
		chk("fires", 64'(c0 + 1), 64'(npa));
		wr(8'h48, 32'h0);
		repeat (3) @(posedge hclk);
		chk("irq_masked", 64'h0, 64'(irq));
		wr(8'h48, 32'h1);
		wr(8'h44, 32'h1);
		repeat (3) @(posedge hclk);
		chk("irq_clr", 64'h0, 64'(irq));
		wr(8'h48, 32'h0);
	endtask

	task automatic t_cyclic;
		set_time(32'h0);
		wr(8'h24, 32'd100);
		wr(8'h00, 32'h14);
		arm(1, 32'd500);
		wait_pulse(1);
		c0 = cyc;
		j = 100 / dcs_pkg::CLK_PERIOD_NS;
		for (i = 0; i < 3; i++)
		begin
			wait_pulse(1);
			chk("period", 64'(j), 64'(cyc - c0));
			c0 = cyc;
		end
		wr(8'h00, 32'h0);
	endtask

	task automatic t_act;
		int a0 [3];
		in_pins <= 8'h5a;
		wr(8'h4c, 32'd2);
		for (i = 1; i < 4; i++)
		begin
			a0 = nact;
			set_time(32'h0);
			wr(8'h00, 32'h2 | 32'(i << 5));
			arm(0, 32'd300);
			wait_pulse(0);
			@(posedge hclk);
			for (j = 0; j < 3; j++)
				chk("act", 64'(j == i - 1), 64'(nact[j] - a0[j]));
		end
		wr(8'h00, 32'h0);
		rd(8'h40);
		chk("sample", 64'h5a, 64'(r[7:0]));
		wr(8'h44, 32'h3f);
		fo.delete();
		partner_u.send(1'b1, 4);
		repeat (3) @(posedge hclk);
		chk("frame_len", 64'h4, 64'(fo.size()));
		for (i = 0; i < 4; i++)
		begin
			j = (i == 2) ? 8'h5a : 8'h10 + i;
			chk("frame_byte", 64'(j), 64'(fo[i]));
		end
		rd(8'h44);
		chk("fresh", 64'h0, 64'(r[4]));
		partner_u.send(1'b1, 4);
		repeat (3) @(posedge hclk);
		rd(8'h44);
		chk("stale", 64'h1, 64'(r[4]));
	endtask

	task automatic t_cap;
		for (i = 0; i < 4; i++)
		begin
			wr(8'h00, 32'(i << 9));
			wr(8'h44, 32'h3f);
			rd(8'h04);
			t0 = r;
			case (i)
				0, 1: partner_u.send(1'b0, 3);
				2:
				begin
					latch_pin <= 2'b01;
					repeat (5) @(posedge hclk);
					latch_pin <= 2'b00;
				end
				default:
				begin
					uc_comm <= 1'b1;
					@(posedge hclk);
					uc_comm <= 1'b0;
				end
			endcase
			chk_lat(8'h28, 2);
			if (i == 0)
				chk_lat(8'h30, 3);
		end
		for (i = 0; i < 2; i++)
		begin
			wr(8'h44, 32'h3f);
			rd(8'h04);
			t0 = r;
			partner_u.dm(i);
			chk_lat(8'(8'h38 + 4 * i), 5);
		end
	endtask

	initial
	begin
		hresetn = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		uc_comm = 1'b0;
		in_pins = 8'h00;
		latch_pin = 2'b00;
		failures = 0;
		n_tests = 0;
		cyc = 0;
		npa = 0;
		nact = '{0, 0, 0};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_time;
		t_once;
		t_cyclic;
		t_act;
		t_cap;
		print_verdict;
	end

	// A hang anywhere counts as a mismatch and ends the run.
	initial
	begin
		repeat (100000) @(posedge hclk);
		failures++;
		print_verdict;
	end
endmodule
